// [tb.sv]
// self-checking testbench of the timer core
`timescale 1ns/1ps
`default_nettype none

module tb;
	import utc_pkg::*;
	// ****************
	// bench
	// ****************
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	utc_clk_in_t ci;
	logic [31:0] q[$];
	int err_count, comparisons, cyc, n;
	utc_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .clk_in(ci), .irq(irq));
	initial begin
		pclk = 0;
		forever #4 pclk = ~pclk;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	task report_and_stop;
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : report_and_stop
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 0;
		penable <= 0;
	endtask : apb
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1, a, d);
	endtask : wr
	task rd(input logic [11:0] a, input logic [31:0] e);
		q.push_back(e);
		apb(0, a, 0);
	endtask : rd
	// source edges of 4 cycles high and 4 low, then time to settle
	task edges(input int b, input int k);
		repeat (k) begin
			ci[b] <= 1;
			repeat (4) @(posedge pclk);
			ci[b] <= 0;
			repeat (4) @(posedge pclk);
		end
		repeat (8) @(posedge pclk);
	endtask : edges
	function automatic logic [31:0] cw(input int s, input int d, input int m, input int e);
		return 32'(s * 256 + d * 64 + m * 16 + e * 2);
	endfunction : cw
	// every access edge: read data against the oldest note, error flag against the map
	always @(posedge pclk)
		if (psel && penable && pready === 1'b1) begin
			if (!pwrite)
				check(prdata, q.pop_front());
			check({31'h0, pslverr}, {31'h0, !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00c})});
		end
	initial begin
		cyc = 0;
		forever @(posedge pclk) begin
			cyc++;
			if (cyc == 30000) begin
				err_count++;
				report_and_stop;
			end
		end
	end
	// ****************
	// scenarios
	// ****************
	initial begin
		ci = '0;
		{psel, penable, pwrite, paddr, pwdata, presetn} = '0;
		void'($urandom(32'h21d26f3e));
		repeat (20) @(posedge pclk);
		presetn <= 1;
		for (int a = 0; a < 5; a++)
			rd(12'(a * 4), 0);
		for (int s = 0; s < 4; s++) begin
			wr(12'h004, 0);
			wr(12'h000, cw(s, 0, 2, 0));
			edges(3 - (s + 1) % 4, 3);
			n = $urandom_range(1, 5);
			edges(3 - s, n);
			rd(12'h004, n);
		end
		for (int d = 0; d < 4; d++) begin
			wr(12'h000, cw(1, d, 2, 0) + 4);
			edges(2, 8);
			rd(12'h004, 8 >> d);
		end
		wr(12'h000, cw(1, 0, 0, 0));
		edges(2, 3);
		rd(12'h004, 1);
		// a half-filled divide-by-2 prescaler must restart after a clear
		wr(12'h000, cw(1, 1, 2, 0) + 4);
		edges(2, 1);
		wr(12'h000, cw(1, 1, 2, 0) + 4);
		edges(2, 1);
		rd(12'h004, 0);
		r = $urandom_range(0, 16'hffff);
		wr(12'h004, r);
		rd(12'h004, r);
		wr(12'h008, 2);
		wr(12'h00c, 1);
		wr(12'h000, cw(1, 0, 1, 1) + 4);
		edges(2, 2);
		rd(12'h004, 2);
		rd(12'h00c, 5);
		edges(2, 1);
		rd(12'h000, cw(1, 0, 1, 1) + 1);
		check({31'h0, irq}, 1);
		wr(12'h000, cw(1, 0, 0, 0) + 1);
		repeat (2) @(posedge pclk);
		check({31'h0, irq}, 0);
		wr(12'h004, 16'hffff);
		rd(12'h000, cw(1, 0, 0, 0));
		wr(12'h000, cw(1, 0, 2, 0));
		edges(2, 1);
		rd(12'h004, 0);
		rd(12'h000, cw(1, 0, 2, 0) + 1);
		wr(12'h000, cw(1, 0, 0, 0) + 1);
		wr(12'h004, 16'h0010);
		wr(12'h000, cw(1, 0, 1, 0));
		rd(12'h004, 0);
		wr(12'h00c, 1);
		wr(12'h000, cw(1, 0, 3, 0) + 4);
		edges(2, 3);
		rd(12'h00c, 7);
		wr(12'h000, cw(1, 0, 0, 0));
		wr(12'h000, cw(1, 0, 3, 0));
		edges(2, 1);
		rd(12'h004, 0);
		rd(12'h000, cw(1, 0, 3, 0) + 1);
		wr(12'h000, cw(1, 0, 0, 0) + 1);
		wr(12'h004, 1);
		wr(12'h000, cw(1, 0, 1, 0));
		wr(12'h008, 0);
		edges(2, 2);
		rd(12'h004, 1);
		wr(12'h008, 3);
		rd(12'h004, 0);
		edges(2, 2);
		rd(12'h004, 2);
		// period shrunk below the running count: next count wraps to zero
		wr(12'h008, 1);
		edges(2, 1);
		rd(12'h004, 0);
		report_and_stop;
	end
endmodule : tb
`default_nettype wire

// [utc_cfg.svh]
// register offsets, field positions, reset values and timing counts of the timer core
`ifndef UTC_CFG_SVH
`define UTC_CFG_SVH

`define UTC_ADDR_W 12
`define UTC_OFF_CTRL 12'h000
`define UTC_OFF_COUNT 12'h004
`define UTC_OFF_PERIOD 12'h008
`define UTC_OFF_STATUS 12'h00c

// control register fields
`define UTC_CTRL_OVF_FLAG 0
`define UTC_CTRL_OVF_IE 1
`define UTC_CTRL_CLEAR 2
`define UTC_CTRL_MODE_LO 4
`define UTC_CTRL_DIV_LO 6
`define UTC_CTRL_SRC_LO 8

// status register fields
`define UTC_STAT_CMP_FLAG 0
`define UTC_STAT_DOWN 1
`define UTC_STAT_RUNNING 2

`define UTC_COUNT_MAX 16'hffff
`define UTC_COUNT_RST 16'h0000
`define UTC_PERIOD_RST 16'h0000
`define UTC_SYNC_STAGES 2

`endif

// [utc_clk_sel.sv]
// clock source synchroniser, selector and rising edge detector
`timescale 1ns/1ps
`default_nettype none

module utc_clk_sel (
	// system
	input wire logic pclk,
	input wire logic presetn,
	// sources and selection
	input wire utc_pkg::utc_clk_in_t clk_in,
	input wire utc_pkg::utc_src_t sel,
	// one pclk pulse per rising edge of the selected source
	output logic tick
);
	import utc_pkg::*;

	logic [3:0] meta;
	logic [3:0] sync;
	logic [3:0] prev;
	logic [3:0] rise;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta <= 4'h0;
			sync <= 4'h0;
			prev <= 4'h0;
		end else begin
			meta <= {clk_in.external_clock_b, clk_in.subsystem_clock,
				clk_in.aux_clock, clk_in.external_clock_a};
			sync <= meta;
			prev <= sync;
		end
	end

	assign rise = sync & ~prev;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick <= 1'b0;
		end else begin
			case (sel)
				UTC_SRC_EXT_A: tick <= rise[0];
				UTC_SRC_AUX: tick <= rise[1];
				UTC_SRC_SUBSYS: tick <= rise[2];
				UTC_SRC_EXT_B: tick <= rise[3];
				default: tick <= 1'b0;
			endcase
		end
	end

endmodule : utc_clk_sel

`default_nettype wire

// [utc_pkg.sv]
// types shared by the timer core and its clock source selector
package utc_pkg;

	typedef enum logic [1:0] {
		UTC_MODE_STOP = 2'h0,
		UTC_MODE_UP = 2'h1,
		UTC_MODE_CONT = 2'h2,
		UTC_MODE_UPDOWN = 2'h3
	} utc_mode_t;

	typedef enum logic [1:0] {
		UTC_SRC_EXT_A = 2'h0,
		UTC_SRC_AUX = 2'h1,
		UTC_SRC_SUBSYS = 2'h2,
		UTC_SRC_EXT_B = 2'h3
	} utc_src_t;

	typedef struct packed {
		logic external_clock_a;
		logic aux_clock;
		logic subsystem_clock;
		logic external_clock_b;
	} utc_clk_in_t;

	typedef struct packed {
		utc_src_t clock_source_select;
		logic [1:0] prescale_select;
		utc_mode_t mode_control_field;
	} utc_ctrl_t;

endpackage : utc_pkg

// [utc_timer.sv]
// 16-bit up/down timer counter core with an APB register slave
`timescale 1ns/1ps
`default_nettype none
`include "utc_cfg.svh"

// How it works
// - 16-bit count steps up or down on each prescaled timer clock tick.
// - clear bit zeroes count, resets prescaler and up/down direction.
// - software write to the count takes effect at once.
// - timer clock picks one of four sources by the source select field.
// - prescaler divides the selected clock by 1, 2, 4 or 8.
// - counting happens only with nonzero mode and a running clock.
// - zero period stops up modes; nonzero restarts from zero counting up.
// - mode field: 00 stop, 01 up, 10 continuous, 11 up/down.
// - continuous mode counts zero to ffff then wraps to zero.
// - up mode counts zero to period then restarts, period plus one counts.
// - entering up mode with count above period restarts at zero.
// - up mode sets compare flag on counting to the period.
// - up mode sets overflow flag counting from period to zero.
// - new period continues up, or wraps when below the count.
// - flags set only by counting, never by a direct count write.
// - continuous mode sets overflow flag counting ffff to zero.
// - up/down mode sets overflow flag counting down 1 to 0.
// - up/down direction is latched across a stop.
module utc_timer (
	// system
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`UTC_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// timer clock sources
	input wire utc_pkg::utc_clk_in_t clk_in,
	// interrupt request
	output logic irq
);
	import utc_pkg::*;

	// ****************************************************************
	// state
	// ****************************************************************
	utc_ctrl_t ctrl;
	logic ovf_ie;
	logic timer_overflow_flag;
	logic compare_match_flag;
	logic [15:0] count_value;
	logic [15:0] period_register;
	logic count_down;
	logic [2:0] prescale_cnt;
	logic src_tick;
	logic tick;
	logic ovf_set;
	logic cmp_set;

	// ****************************************************************
	// bus decode
	// ****************************************************************
	logic wr_en;
	logic setup;
	logic wr_ctrl;
	logic wr_count;
	logic wr_period;
	logic wr_status;
	logic clear_req;
	logic [15:0] wr_word;

	function automatic logic hit(input logic [`UTC_ADDR_W-1:0] a,
		input logic [`UTC_ADDR_W-1:0] off);
		hit = (a == off);
	endfunction : hit

	function automatic logic mapped(input logic [`UTC_ADDR_W-1:0] a);
		mapped = hit(a, `UTC_OFF_CTRL) | hit(a, `UTC_OFF_COUNT) |
			hit(a, `UTC_OFF_PERIOD) | hit(a, `UTC_OFF_STATUS);
	endfunction : mapped

	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pready & pwrite;
	assign wr_ctrl = wr_en & hit(paddr, `UTC_OFF_CTRL);
	assign wr_count = wr_en & hit(paddr, `UTC_OFF_COUNT);
	assign wr_period = wr_en & hit(paddr, `UTC_OFF_PERIOD);
	assign wr_status = wr_en & hit(paddr, `UTC_OFF_STATUS);
	assign clear_req = wr_ctrl & pwdata[`UTC_CTRL_CLEAR];
	assign wr_word = pwdata[15:0];

	// answer registered one cycle after setup: no wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			pslverr <= setup & ~mapped(paddr);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup & ~pwrite) begin
			case (paddr)
				`UTC_OFF_CTRL: prdata <= {22'h00_0000, ctrl, 1'b0, 1'b0,
					ovf_ie, timer_overflow_flag};
				`UTC_OFF_COUNT: prdata <= {16'h0000, count_value};
				`UTC_OFF_PERIOD: prdata <= {16'h0000, period_register};
				`UTC_OFF_STATUS: prdata <= {29'h0000_0000,
					(ctrl.mode_control_field != UTC_MODE_STOP), count_down,
					compare_match_flag};
				default: prdata <= 32'h0000_0000;
			endcase
		end else begin
			prdata <= 32'h0000_0000;
		end
	end

	// ****************************************************************
	// configuration registers
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= '{UTC_SRC_EXT_A, 2'h0, UTC_MODE_STOP};
			ovf_ie <= 1'b0;
		end else if (wr_ctrl) begin
			ctrl.clock_source_select <= utc_src_t'(pwdata[`UTC_CTRL_SRC_LO +: 2]);
			ctrl.prescale_select <= pwdata[`UTC_CTRL_DIV_LO +: 2];
			ctrl.mode_control_field <= utc_mode_t'(pwdata[`UTC_CTRL_MODE_LO +: 2]);
			ovf_ie <= pwdata[`UTC_CTRL_OVF_IE];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			period_register <= `UTC_PERIOD_RST;
		end else if (wr_period) begin
			period_register <= wr_word;
		end
	end

	// ****************************************************************
	// clock source and prescaler
	// ****************************************************************
	utc_clk_sel u_clk_sel (
		.pclk(pclk),
		.presetn(presetn),
		.clk_in(clk_in),
		.sel(ctrl.clock_source_select),
		.tick(src_tick)
	);

	logic [2:0] div_last;
	assign div_last = 3'((4'h1 << ctrl.prescale_select) - 4'h1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prescale_cnt <= 3'h0;
		end else if (clear_req) begin
			prescale_cnt <= 3'h0;
		end else if (src_tick) begin
			prescale_cnt <= (prescale_cnt >= div_last) ? 3'h0 : prescale_cnt + 3'h1;
		end
	end

	// count tick only with a running mode and a live source
	assign tick = src_tick & (prescale_cnt >= div_last) &
		(ctrl.mode_control_field != UTC_MODE_STOP);

	// ****************************************************************
	// counter
	// ****************************************************************
	logic period_zero;
	logic up_mode_entry;
	logic period_restart;
	logic [15:0] next_count;
	logic next_down;

	assign period_zero = (period_register == 16'h0000);
	// up mode entered with the count past the period
	assign up_mode_entry = wr_ctrl &&
		(utc_mode_t'(pwdata[`UTC_CTRL_MODE_LO +: 2]) == UTC_MODE_UP) &&
		(count_value > period_register);
	// period taken from zero to nonzero under an up mode
	assign period_restart = wr_period && period_zero && (wr_word != 16'h0000) &&
		((ctrl.mode_control_field == UTC_MODE_UP) ||
		(ctrl.mode_control_field == UTC_MODE_UPDOWN));

	always_comb begin
		next_count = count_value;
		next_down = count_down;
		ovf_set = 1'b0;
		cmp_set = 1'b0;
		if (tick) begin
			case (ctrl.mode_control_field)
				UTC_MODE_UP: begin
					if (!period_zero) begin
						if (count_value >= period_register) begin
							next_count = 16'h0000;
							ovf_set = (count_value == period_register);
						end else begin
							next_count = count_value + 16'h0001;
							cmp_set = (next_count == period_register);
						end
					end
				end
				UTC_MODE_CONT: begin
					next_count = count_value + 16'h0001;
					ovf_set = (count_value == `UTC_COUNT_MAX);
					cmp_set = (next_count == period_register);
				end
				UTC_MODE_UPDOWN: begin
					if (!period_zero) begin
						if (!count_down) begin
							if (count_value >= period_register) begin
								next_count = count_value - 16'h0001;
								next_down = 1'b1;
							end else begin
								next_count = count_value + 16'h0001;
								cmp_set = (next_count == period_register);
							end
						end else if (count_value == 16'h0000) begin
							next_count = 16'h0001;
							next_down = 1'b0;
						end else begin
							next_count = count_value - 16'h0001;
							if (count_value == 16'h0001) begin
								ovf_set = 1'b1;
								next_down = 1'b0;
							end
						end
					end
				end
				default: begin
					next_count = count_value;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_value <= `UTC_COUNT_RST;
		end else if (clear_req) begin
			count_value <= 16'h0000;
		end else if (wr_count) begin
			count_value <= wr_word;
		end else if (up_mode_entry || period_restart) begin
			count_value <= 16'h0000;
		end else begin
			count_value <= next_count;
		end
	end

	// direction holds while stopped, so up/down resumes the same way
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_down <= 1'b0;
		end else if (clear_req || period_restart) begin
			count_down <= 1'b0;
		end else begin
			count_down <= next_down;
		end
	end

	// ****************************************************************
	// flags and interrupt
	// ****************************************************************
	// write one clears; a set in the same cycle wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_overflow_flag <= 1'b0;
		end else begin
			timer_overflow_flag <= (timer_overflow_flag &
				~(wr_ctrl & pwdata[`UTC_CTRL_OVF_FLAG])) | ovf_set;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			compare_match_flag <= 1'b0;
		end else begin
			compare_match_flag <= (compare_match_flag &
				~(wr_status & pwdata[`UTC_STAT_CMP_FLAG])) | cmp_set;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= timer_overflow_flag & ovf_ie;
		end
	end

endmodule : utc_timer

`default_nettype wire

// [utc_timer_assertions.sv]
// port protocol checker of the timer core
`timescale 1ns/1ps
`default_nettype none
`include "utc_cfg.svh"

module utc_timer_chk (
	// system
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`UTC_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// interrupt
	input wire logic irq
);
	// ****************
	// assertions
	// ****************
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic setup;
	logic mapped;
	assign setup = psel && !penable;
	assign mapped = paddr inside {12'h000, 12'h004, 12'h008, 12'h00c};
	sequence s_ie_off;
		psel && penable && pready && pwrite && paddr == 12'h000 && !pwdata[1];
	endsequence
	a_ready_after_setup: assert property (setup |=> pready) else $error("ready late");
	a_ready_has_setup: assert property (pready |-> $past(setup)) else $error("stray ready");
	a_ready_one: assert property (pready |=> !pready) else $error("ready too long");
	a_err_unmapped: assert property (setup && !mapped |=> pslverr) else $error("no error");
	a_err_mapped: assert property (setup && mapped |=> !pslverr) else $error("false error");
	a_rdata_idle: assert property (!(pready && !pwrite) |-> prdata == 32'h0) else $error("rdata");
	a_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0) else $error("upper");
	a_clear_reads: assert property (pready && !pwrite && paddr == 12'h000 |->
		prdata[3:2] == 2'b00 && prdata[15:10] == 6'h0) else $error("ctrl bits");
	a_irq_off: assert property (s_ie_off |-> ##2 !irq) else $error("irq stays");
endmodule : utc_timer_chk

bind utc_timer utc_timer_chk utc_timer_chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .irq(irq));
`default_nettype wire
